// ### logic/flag_unit.sv
// Purpose: Flag results of bit-test and test-equivalence.
// Assumes: The shifted second operand and its carry come from the decoder.
// Notes: Purely combinational; caller decides whether to commit.
`timescale 1ns/1ps
module flag_unit
  import alu_pkg::*;
(
  // Operands
  input wire logic [alu_pkg::DATA_W-1:0] first_operand_register,
  input wire logic [alu_pkg::DATA_W-1:0] flexible_second_operand,
  input wire logic equivalence,
  // Shifter carry
  input wire logic carry_valid,
  input wire logic carry_in,
  // Flags
  input wire logic [alu_pkg::FLAG_W-1:0] flags_in,
  output logic [alu_pkg::FLAG_W-1:0] flags_out
);

  logic [DATA_W-1:0] value;

  always_comb begin
    if (equivalence) begin
      value = first_operand_register ^ flexible_second_operand;
    end else begin
      value = first_operand_register & flexible_second_operand;
    end
    flags_out = flags_in;
    flags_out[FLAG_N] = value[DATA_W-1];
    flags_out[FLAG_Z] = (value == '0);
    flags_out[FLAG_C] = carry_valid ? carry_in : flags_in[FLAG_C];
    flags_out[FLAG_V] = flags_in[FLAG_V];
  end

endmodule : flag_unit

// ### logic/halving_lane.sv
// Purpose: One signed lane adder/subtractor with optional halving.
// Assumes: Operands are two's complement of width W.
// Notes: One guard bit keeps the halved result exact.
`timescale 1ns/1ps
module halving_lane #(
  parameter int unsigned W = 16
) (
  // Operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  // Mode
  input wire logic sub,
  input wire logic half,
  // Result
  output logic [W-1:0] y
);

  logic [W:0] ext;

  // A one-bit lane has no room for the sign, so refuse it at elaboration
  if (W < 2) begin : g_w_check
    $error("halving_lane: W must be at least 2");
  end

  always_comb begin
    if (sub) begin
      ext = {a[W-1], a} - {b[W-1], b};
    end else begin
      ext = {a[W-1], a} + {b[W-1], b};
    end
    y = half ? ext[W:1] : ext[W-1:0];
  end

endmodule : halving_lane

// ### logic/simd_halving_sub_test_alu.sv
// Purpose: Packed signed subtract/exchange and bit-test datapath slice.
// Assumes: Decoder writes operands, then control with the go bit set.
// Notes: Results and flags commit two cycles after the control write.
//
// How it works
// - Halving halfword subtract, shift each difference right
// - Halving byte subtract, four halved signed differences
// - Two signed halfword differences into matching halves
// - Four signed byte differences into matching bytes
// - Halving add-sub exchange: top add, bottom subtract
// - Halving sub-add exchange: top subtract, bottom add
// - Add-sub exchange: top is first top plus second bottom
// - Exchange operations leave every flag unchanged
// - Packed and halving subtracts leave flags unchanged
// - Bit-test ANDs first register with second operand
// - Test-equivalence XORs first register with second operand
// - Bit-test and equivalence never write a result
// - Negative is result MSB, zero when all zero
// - Carry takes shifter carry-out, else unchanged
// - Overflow flag never altered by tests
// - Failed condition commits neither result nor flags
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module simd_halving_sub_test_alu
  import alu_pkg::*;
#(
  parameter int unsigned WIDTH = 32
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave request
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // AHB-Lite slave answer
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Architectural outputs toward the core
  output logic [alu_pkg::DATA_W-1:0] result,
  output logic result_write,
  output logic [alu_pkg::FLAG_W-1:0] flags,
  output logic flags_write
);

  if (WIDTH != DATA_W) begin : g_width_check
    $error("simd_halving_sub_test_alu: WIDTH must equal 32");
  end

  // Bus tracking
  logic wr_pend_q;
  logic rd_pend_q;
  logic [ADDR_W-1:0] addr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic take;

  // Register file
  logic [DATA_W-1:0] opa_q;
  logic [DATA_W-1:0] opb_q;
  logic [CTRL_KEEP_W-1:0] ctrl_q;
  logic [DATA_W-1:0] result_q;
  logic [FLAG_W-1:0] flags_q;
  logic [STAT_W-1:0] status_q;
  logic result_write_q;
  logic flags_write_q;

  // Sequencer
  state_e state_q;
  state_e state_d;
  logic go;
  logic sw_write;

  // Datapath
  op_e op;
  logic op_valid;
  logic is_exchange;
  logic is_asx;
  logic is_half;
  logic is_byte;
  logic is_test;
  logic [1:0] hw_sub;
  logic [1:0] hw_half;
  logic [DATA_W-1:0] hw_res;
  logic [DATA_W-1:0] byte_res;
  logic [DATA_W-1:0] alu_res;
  logic [FLAG_W-1:0] test_flags;
  logic [DATA_W-1:0] exec_res_q;
  logic [FLAG_W-1:0] exec_flags_q;
  logic exec_wr_res_q;
  logic exec_wr_flags_q;
  logic exec_ok_q;
  logic exec_bad_q;

  // Address phase: only whole-word writes are accepted; reads of any size are taken
  assign take = hsel && hready && htrans[1];
  assign addr_ok = (haddr[31:ADDR_W] == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
    end else if (take) begin
      wr_pend_q <= hwrite && (hsize == HSIZE_WORD) && addr_ok;
      rd_pend_q <= !hwrite;
      addr_q <= addr_ok ? haddr[ADDR_W-1:0] : '1;
    end else if (hready) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else if (rd_pend_q) begin
      rd_pend_q <= 1'b0;
    end
  end

  // Reads insert one wait state so read data comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else if (take && !hwrite) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= READ_ZERO;
    end else if (rd_pend_q && !hreadyout_q) begin
      case (addr_q)
        OFS_FIRST_OPERAND: hrdata_q <= opa_q;
        OFS_SECOND_OPERAND: hrdata_q <= opb_q;
        OFS_CONTROL: hrdata_q <= {25'h0, ctrl_q};
        OFS_RESULT: hrdata_q <= result_q;
        OFS_FLAGS: hrdata_q <= {28'h0, flags_q};
        OFS_STATUS: hrdata_q <= {27'h0, status_q};
        default: hrdata_q <= READ_ZERO;
      endcase
    end
  end

  // Software writes land at the end of the write data phase
  assign sw_write = wr_pend_q && hreadyout_q && (state_q == st_idle);
  assign go = sw_write && (addr_q == OFS_CONTROL) && hwdata[CTRL_GO_BIT];

  // Operands and control are locked while an operation is in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opa_q <= OPERAND_RESET;
      opb_q <= OPERAND_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (sw_write) begin
      case (addr_q)
        OFS_FIRST_OPERAND: opa_q <= hwdata;
        OFS_SECOND_OPERAND: opb_q <= hwdata;
        OFS_CONTROL: ctrl_q <= hwdata[CTRL_KEEP_W-1:0];
        default: ;
      endcase
    end
  end

  // Sequencer
  always_comb begin
    case (state_q)
      st_idle: state_d = go ? st_exec : st_idle;
      st_exec: state_d = st_commit;
      st_commit: state_d = st_idle;
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // Decode
  assign op = op_e'(ctrl_q[CTRL_OP_LSB +: OP_W]);

  always_comb begin
    op_valid = 1'b1;
    is_exchange = 1'b0;
    is_asx = 1'b0;
    is_half = 1'b0;
    is_byte = 1'b0;
    is_test = 1'b0;
    case (op)
      op_signed_halving_halfword_subtract: is_half = 1'b1;
      op_signed_halving_byte_subtract: begin
        is_half = 1'b1;
        is_byte = 1'b1;
      end
      op_signed_halfword_subtract: ;
      op_signed_byte_subtract: is_byte = 1'b1;
      op_signed_halving_add_sub_exchange: begin
        is_half = 1'b1;
        is_exchange = 1'b1;
        is_asx = 1'b1;
      end
      op_signed_halving_sub_add_exchange: begin
        is_half = 1'b1;
        is_exchange = 1'b1;
      end
      op_signed_add_sub_exchange: begin
        is_exchange = 1'b1;
        is_asx = 1'b1;
      end
      op_signed_sub_add_exchange: is_exchange = 1'b1;
      op_bit_test, op_test_equivalence: is_test = 1'b1;
      default: op_valid = 1'b0;
    endcase
  end

  // Lane modes: exchange adds in the top lane for add-sub, bottom for sub-add
  always_comb begin
    hw_sub[1] = !(is_exchange && is_asx);
    hw_sub[0] = !(is_exchange && !is_asx);
    hw_half = {2{is_half}};
  end

  // Halfword lanes; exchange swaps the second operand's halves
  for (genvar h = 0; h < 2; h++) begin : g_half
    halving_lane #(
      .W(16)
    ) u_lane (
      .a(opa_q[16*h +: 16]),
      .b(is_exchange ? opb_q[16*(1-h) +: 16] : opb_q[16*h +: 16]),
      .sub(hw_sub[h]),
      .half(hw_half[h]),
      .y(hw_res[16*h +: 16])
    );
  end

  // Byte lanes always subtract
  for (genvar k = 0; k < 4; k++) begin : g_byte
    halving_lane #(
      .W(8)
    ) u_lane (
      .a(opa_q[8*k +: 8]),
      .b(opb_q[8*k +: 8]),
      .sub(1'b1),
      .half(is_half),
      .y(byte_res[8*k +: 8])
    );
  end

  assign alu_res = is_byte ? byte_res : hw_res;

  flag_unit u_flags (
    .first_operand_register(opa_q),
    .flexible_second_operand(opb_q),
    .equivalence(op == op_test_equivalence),
    .carry_valid(ctrl_q[CTRL_CARRY_VALID_BIT]),
    .carry_in(ctrl_q[CTRL_CARRY_BIT]),
    .flags_in(flags_q),
    .flags_out(test_flags)
  );

  // Execute stage registers the lane outputs to keep the adders off the commit path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exec_res_q <= RESULT_RESET;
      exec_flags_q <= FLAGS_RESET;
      exec_wr_res_q <= 1'b0;
      exec_wr_flags_q <= 1'b0;
      exec_ok_q <= 1'b0;
      exec_bad_q <= 1'b0;
    end else if (state_q == st_exec) begin
      exec_res_q <= alu_res;
      exec_flags_q <= test_flags;
      exec_wr_res_q <= op_valid && !is_test;
      exec_wr_flags_q <= is_test;
      exec_ok_q <= ctrl_q[CTRL_COND_BIT] && op_valid;
      exec_bad_q <= !op_valid;
    end
  end

  // Commit: a failed condition or an unknown operation changes nothing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= RESULT_RESET;
      result_write_q <= 1'b0;
    end else if (state_q == st_commit && exec_ok_q && exec_wr_res_q) begin
      result_q <= exec_res_q;
      result_write_q <= 1'b1;
    end else begin
      result_write_q <= 1'b0;
    end
  end

  // Flags are also writable by software while idle, to seed carry and overflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= FLAGS_RESET;
      flags_write_q <= 1'b0;
    end else if (state_q == st_commit && exec_ok_q && exec_wr_flags_q) begin
      flags_q <= exec_flags_q;
      flags_write_q <= 1'b1;
    end else begin
      flags_write_q <= 1'b0;
      if (sw_write && addr_q == OFS_FLAGS) begin
        flags_q <= hwdata[FLAG_W-1:0];
      end
    end
  end

  // Status: done and outcome bits hold until the next go
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
    end else begin
      status_q[STAT_BUSY] <= (state_d != st_idle);
      if (go) begin
        status_q[STAT_DONE] <= 1'b0;
        status_q[STAT_SKIPPED] <= 1'b0;
        status_q[STAT_BAD_OP] <= 1'b0;
        status_q[STAT_WROTE_RESULT] <= 1'b0;
      end else if (state_q == st_commit) begin
        status_q[STAT_DONE] <= 1'b1;
        status_q[STAT_SKIPPED] <= !exec_ok_q;
        status_q[STAT_BAD_OP] <= exec_bad_q;
        status_q[STAT_WROTE_RESULT] <= exec_ok_q && exec_wr_res_q;
      end
    end
  end

  // Outputs
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = HRESP_OKAY;
  assign result = result_q;
  assign result_write = result_write_q;
  assign flags = flags_q;
  assign flags_write = flags_write_q;

endmodule : simd_halving_sub_test_alu

// ### shared/alu_pkg.sv
// Purpose: Shared constants and types for the packed signed datapath slice.
// Assumes: 32-bit AHB-Lite register access, word transfers only.
// Notes: Offsets are byte addresses within the slave window.
package alu_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned OP_W = 4;
  localparam int unsigned FLAG_W = 4;

  // Register offsets
  localparam logic [7:0] OFS_FIRST_OPERAND = 8'h00;
  localparam logic [7:0] OFS_SECOND_OPERAND = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Control fields
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned CTRL_COND_BIT = 4;
  localparam int unsigned CTRL_CARRY_VALID_BIT = 5;
  localparam int unsigned CTRL_CARRY_BIT = 6;
  localparam int unsigned CTRL_GO_BIT = 8;
  localparam int unsigned CTRL_KEEP_W = 7;

  // Flag bit positions
  localparam int unsigned FLAG_V = 0;
  localparam int unsigned FLAG_C = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_N = 3;

  // Status bit positions
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_SKIPPED = 2;
  localparam int unsigned STAT_BAD_OP = 3;
  localparam int unsigned STAT_WROTE_RESULT = 4;
  localparam int unsigned STAT_W = 5;

  // Reset values
  localparam logic [31:0] OPERAND_RESET = 32'h0000_0000;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    op_signed_halving_halfword_subtract = 4'h0,
    op_signed_halving_byte_subtract = 4'h1,
    op_signed_halfword_subtract = 4'h2,
    op_signed_byte_subtract = 4'h3,
    op_signed_halving_add_sub_exchange = 4'h4,
    op_signed_halving_sub_add_exchange = 4'h5,
    op_signed_add_sub_exchange = 4'h6,
    op_signed_sub_add_exchange = 4'h7,
    op_bit_test = 4'h8,
    op_test_equivalence = 4'h9
  } op_e;

  // Gray order along idle, execute, commit
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_exec = 2'h1,
    st_commit = 2'h3
  } state_e;

endpackage : alu_pkg

// ### test/alu_chk.sv
// Purpose: Bus timing and commit checks for the datapath slice.
// Assumes: One slave, hready looped back from hreadyout.
// Notes: Shadows operand and control writes to predict test flags.
`timescale 1ns/1ps
module alu_chk
  import alu_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus request
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Bus answer
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Core side
  input wire logic [alu_pkg::DATA_W-1:0] result,
  input wire logic result_write,
  input wire logic [alu_pkg::FLAG_W-1:0] flags,
  input wire logic flags_write
);
  logic wph_q;
  logic go_q;
  logic [31:0] wad_q;
  logic [31:0] opa_q;
  logic [31:0] opb_q;
  logic [6:0] ctl_q;
  logic [31:0] val;
  assign val = (ctl_q[3:0] == 4'h9) ? (opa_q ^ opb_q) : (opa_q & opb_q);
  // Busy-time writes are not filtered here; the bench never issues them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q <= 1'b0;
      go_q <= 1'b0;
      wad_q <= 32'h0;
      opa_q <= 32'h0;
      opb_q <= 32'h0;
      ctl_q <= 7'h00;
    end else begin
      go_q <= 1'b0;
      if (hready) begin
        wph_q <= hsel && htrans[1] && hwrite && hsize == HSIZE_WORD;
        wad_q <= haddr;
      end
      if (hready && wph_q) begin
        if (wad_q == 32'(OFS_FIRST_OPERAND)) opa_q <= hwdata;
        if (wad_q == 32'(OFS_SECOND_OPERAND)) opb_q <= hwdata;
        if (wad_q == 32'(OFS_CONTROL)) begin
          ctl_q <= hwdata[6:0];
          go_q <= hwdata[8];
        end
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hsel && hready && htrans[1] |=> hresp == HRESP_OKAY)
    else $error("response not okay");
  a_commit_time: assert property (go_q && ctl_q[4] && ctl_q[3:0] < 4'h8
    |-> ##2 result_write && !flags_write) else $error("result commit late");
  a_test_time: assert property (go_q && ctl_q[4] && ctl_q[3:0] inside {4'h8, 4'h9}
    |-> ##2 flags_write && !result_write ##1 !flags_write) else $error("flag commit wrong");
  a_skip_none: assert property (go_q && (!ctl_q[4] || ctl_q[3:0] > 4'h9)
    |-> (!result_write && !flags_write) [*4]) else $error("skipped op committed");
  a_flags_kept: assert property (result_write |-> $stable(flags))
    else $error("flags moved on result");
  a_nz_flags: assert property (flags_write |-> flags[FLAG_N] == val[31]
    && flags[FLAG_Z] == (val == 32'h0)) else $error("N or Z wrong");
  a_cv_flags: assert property (flags_write |-> flags[FLAG_V] == $past(flags[FLAG_V])
    && flags[FLAG_C] == (ctl_q[5] ? ctl_q[6] : $past(flags[FLAG_C]))) else $error("C or V wrong");
endmodule : alu_chk

bind simd_halving_sub_test_alu alu_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .result,
  .result_write, .flags, .flags_write);

// ### test/core_regfile_model.sv
// Purpose: Core register file that takes committed results and flags.
// Assumes: Commits arrive as one-cycle pulses.
// Notes: Stack pointer and program counter are never written.
`timescale 1ns/1ps
module core_regfile_model
  import alu_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Commit side
  input wire logic [3:0] dest,
  input wire logic [alu_pkg::DATA_W-1:0] result,
  input wire logic result_write,
  input wire logic [alu_pkg::FLAG_W-1:0] flags,
  input wire logic flags_write,
  // Read back
  output logic [31:0] dest_value,
  output logic [3:0] apsr
);
  logic [31:0] regs [16];
  assign dest_value = regs[dest];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      apsr <= 4'h0;
    end else begin
      if (result_write && dest < 4'hD) regs[dest] <= result;
      if (flags_write) apsr <= flags;
    end
  end
endmodule : core_regfile_model

// ### test/tb.sv
// Purpose: Self-checking bench for the packed signed datapath slice.
// Assumes: Single AHB-Lite master, hready looped from hreadyout.
// Notes: Expected lanes are worked out here in 32-bit int arithmetic.
`timescale 1ns/1ps
module tb;
  import alu_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, result_write, flags_write;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] flags, fexp, apsr;
  logic [31:0] haddr, hwdata, hrdata, result, dest_value, seed, a, rd, last;
  logic [32:0] note;
  logic [32:0] notes[$];
  int fail_count;
  int checked;
  simd_halving_sub_test_alu u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .result(result),
    .result_write(result_write), .flags(flags), .flags_write(flags_write));
  core_regfile_model u_core (.hclk(hclk), .hresetn(hresetn), .dest(4'h3), .result(result),
    .result_write(result_write), .flags(flags), .flags_write(flags_write),
    .dest_value(dest_value), .apsr(apsr));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic tmo(input int n);
    if (n >= 20) begin
      check("wait bound", 32'h1, 32'h0);
      final_report();
    end
  endtask : tmo
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int sx(logic [31:0] v, int w);
    return (w == 8) ? int'($signed(v[7:0])) : int'($signed(v[15:0]));
  endfunction : sx
  function automatic logic [31:0] exp_res(logic [3:0] op, logic [31:0] x, logic [31:0] y);
    int w;
    int d;
    int t;
    logic [31:0] r;
    w = (op == 4'h1 || op == 4'h3) ? 8 : 16;
    r = 32'h0;
    if (op < 4'h4) begin
      for (int k = 0; k < 32 / w; k++) begin
        d = sx(x >> (k * w), w) - sx(y >> (k * w), w);
        if (op < 4'h2) d = d >>> 1;
        r = r | ((32'(d) & ((w == 8) ? 32'hFF : 32'hFFFF)) << (k * w));
      end
    end else begin
      t = op[0] ? -1 : 1;
      d = sx(x >> 16, 16) + t * sx(y, 16);
      w = sx(x, 16) - t * sx(y >> 16, 16);
      if (op < 4'h6) d = d >>> 1;
      if (op < 4'h6) w = w >>> 1;
      r = {d[15:0], w[15:0]};
    end
    return r;
  endfunction : exp_res
  // Address phase held until hready seen high, then data phase likewise
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] wd,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
    r = hrdata;
    tmo(n);
  endtask : bus
  // cc holds carry value, carry valid, condition passed
  task automatic run(input logic [3:0] op, input logic [31:0] x, input logic [31:0] y,
                     input logic [2:0] cc);
    logic [31:0] v;
    int n;
    v = (op == 4'h9) ? (x ^ y) : (x & y);
    bus(1'b1, 32'(OFS_FIRST_OPERAND), x, rd);
    bus(1'b1, 32'(OFS_SECOND_OPERAND), y, rd);
    if (cc[0] && op < 4'h8) notes.push_back({1'b0, exp_res(op, x, y)});
    if (cc[0] && op < 4'h8) last = exp_res(op, x, y);
    if (cc[0] && op inside {4'h8, 4'h9}) begin
      fexp = {v[31], v == 32'h0, cc[1] ? cc[2] : fexp[FLAG_C], fexp[FLAG_V]};
      notes.push_back({1'b1, 28'h0, fexp});
    end
    bus(1'b1, 32'(OFS_CONTROL), {23'h0, 1'b1, 1'b0, cc, op}, rd);
    n = 0;
    do bus(1'b0, 32'(OFS_STATUS), 32'h0, rd); while (rd[STAT_BUSY] !== 1'b0 && ++n < 20);
    tmo(n);
    check("skip bits", rd & 32'hC, {28'h0, op > 4'h9, !cc[0] || op > 4'h9, 2'h0});
    bus(1'b0, 32'(OFS_RESULT), 32'h0, rd);
    check("result reg", rd, last);
    check("core reg", dest_value, last);
    bus(1'b0, 32'(OFS_FLAGS), 32'h0, rd);
    check("flags reg", rd, {28'h0, fexp});
  endtask : run
  always @(posedge hclk) begin
    if (hresetn === 1'b1 && (result_write === 1'b1 || flags_write === 1'b1)) begin
      if (notes.size() == 0) begin
        check("unexpected commit", 32'h1, 32'h0);
      end else begin
        note = notes.pop_front();
        check("commit kind", {31'h0, flags_write}, {31'h0, note[32]});
        check("commit value", note[32] ? {28'h0, flags} : result, note[31:0]);
      end
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = HSIZE_WORD;
    seed = 32'h4eb5b815;
    fexp = FLAGS_RESET;
    last = RESULT_RESET;
    fail_count = 0;
    checked = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'(OFS_FLAGS), 32'h0, rd);
    check("flags reset", rd, {28'h0, FLAGS_RESET});
    bus(1'b0, 32'h100, 32'h0, rd);
    check("unmapped read", rd, READ_ZERO);
    bus(1'b1, 32'(OFS_RESULT), 32'hFFFF_FFFF, rd);
    bus(1'b0, 32'(OFS_RESULT), 32'h0, rd);
    check("result read only", rd, RESULT_RESET);
    hsize <= 3'h0;
    bus(1'b1, 32'(OFS_FIRST_OPERAND), 32'hA5A5_5A5A, rd);
    hsize <= HSIZE_WORD;
    bus(1'b0, 32'(OFS_FIRST_OPERAND), 32'h0, rd);
    check("byte write ignored", rd, OPERAND_RESET);
    for (int i = 0; i < 10; i++) run(4'(i), 32'h8000_7F80, 32'h7FFF_807F, 3'b001);
    bus(1'b1, 32'(OFS_FLAGS), 32'h3, rd);
    fexp = 4'h3;
    run(4'h9, 32'hA5A5_0F0F, 32'hA5A5_0F0F, 3'b111);
    run(4'h8, 32'hF0F0_0000, 32'h0F0F_FFFF, 3'b011);
    run(4'h2, 32'h1234_5678, 32'h1111_1111, 3'b000);
    run(4'hC, 32'h1234_5678, 32'h1111_1111, 3'b001);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      a = seed;
      seed = lfsr(seed);
      run(4'(a % 10), a, seed, {a[5:4], a[6] | a[7]});
    end
    check("pending commits", 32'(notes.size()), 32'h0);
    final_report();
  end
endmodule : tb
